// ### logic/dspwm_pkg.sv
// Constants and encodings shared by the dual-slope PWM timer
package dspwm_pkg;
   localparam int          CNT_W         = 16;
   localparam int          NUM_CH        = 2;
   localparam int          CH_A          = 0;
   localparam logic [15:0] BOTTOM        = 16'h0000;
   localparam logic [15:0] COUNT_STEP    = 16'h0001;
   localparam logic [15:0] TOP_8BIT      = 16'h00ff;
   localparam logic [15:0] TOP_9BIT      = 16'h01ff;
   localparam logic [15:0] TOP_10BIT     = 16'h03ff;
   localparam logic [15:0] FULL_MASK     = 16'hffff;
   localparam logic [15:0] RESET_VALUE   = 16'h0000;
   localparam logic [3:0]  MODE_PC_8     = 4'h1;
   localparam logic [3:0]  MODE_PC_9     = 4'h2;
   localparam logic [3:0]  MODE_PC_10    = 4'h3;
   localparam logic [3:0]  MODE_PFC_CAP  = 4'h8;
   localparam logic [3:0]  MODE_PFC_CMPA = 4'h9;
   localparam logic [3:0]  MODE_PC_CAP   = 4'ha;
   localparam logic [3:0]  MODE_PC_CMPA  = 4'hb;
   localparam logic [1:0]  OUT_OFF       = 2'h0;
   localparam logic [1:0]  OUT_TOGGLE    = 2'h1;
   localparam logic [1:0]  OUT_NONINV    = 2'h2;
   localparam logic [1:0]  OUT_INV       = 2'h3;
endpackage

// ### logic/dspwm_cnt_if.sv
// Counter state shared from the timer core to its compare channels
`timescale 1ns/1ps
interface dspwm_cnt_if;
   logic        tick;
   logic        dual_active;
   logic [15:0] counter;
   logic        count_up;
   modport core (output tick, output dual_active, output counter, output count_up);
   modport chan (input tick, input dual_active, input counter, input count_up);
endinterface

// ### logic/dspwm_channel.sv
// One compare channel: match detection and waveform register
`timescale 1ns/1ps
module dspwm_channel
   import dspwm_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst,
   dspwm_cnt_if.chan        cnt,
   input  wire logic [15:0] compare,
   input  wire logic [1:0]  out_mode,
   input  wire logic        toggle_ok,
   output      logic        match,
   output      logic        wave_q
);
   logic wave_d;
   logic hit;

   assign hit   = cnt.counter == compare;
   assign match = cnt.tick && cnt.dual_active && hit;

   // Direction at the extremes makes compare 0 stay low and compare TOP stay high in non-inverting mode (the reverse when inverting)
   always_comb begin
      wave_d = wave_q;
      if (match) begin
         unique case (out_mode)
            OUT_NONINV: wave_d = !cnt.count_up;
            OUT_INV:    wave_d = cnt.count_up;
            OUT_TOGGLE: wave_d = toggle_ok ? !wave_q : wave_q;
            OUT_OFF:    wave_d = wave_q;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         wave_q <= 1'b0;
      end else begin
         wave_q <= wave_d;
      end
   end
endmodule // dspwm_channel

// ### logic/dspwm_timer.sv
// Dual-slope PWM timer core: counter, TOP select, buffers, flags, pins
`timescale 1ns/1ps
module dspwm_timer
   import dspwm_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        timer_tick,
   input  wire logic [3:0]  waveform_mode_select,
   input  wire logic [1:0]  output_mode_select_a,
   input  wire logic [1:0]  output_mode_select_b,
   input  wire logic        output_pin_direction_a,
   input  wire logic        output_pin_direction_b,
   input  wire logic [15:0] write_data,
   input  wire logic        compare_write_a,
   input  wire logic        compare_write_b,
   input  wire logic        capture_top_write,
   input  wire logic        overflow_flag_clear,
   input  wire logic        capture_flag_clear,
   input  wire logic        compare_flag_clear_a,
   input  wire logic        compare_flag_clear_b,
   output      logic [15:0] counter_value,
   output      logic        count_down,
   output      logic [15:0] compare_value_a,
   output      logic [15:0] compare_value_b,
   output      logic [15:0] capture_top_register,
   output      logic        overflow_flag,
   output      logic        capture_flag,
   output      logic        compare_flag_a,
   output      logic        compare_flag_b,
   output      logic        compare_output_a,
   output      logic        compare_output_b,
   output      logic        compare_output_a_oe,
   output      logic        compare_output_b_oe
);
   dspwm_cnt_if cnt_bus ();

   logic [15:0] counter_q;
   logic [15:0] counter_d;
   logic        down_q;
   logic        down_d;
   logic [15:0] capture_top_q;
   logic [15:0] capture_top_d;
   logic        overflow_q;
   logic        overflow_d;
   logic        capture_flag_q;
   logic        capture_flag_d;

   logic [NUM_CH-1:0][15:0] buffer_q;
   logic [NUM_CH-1:0][15:0] buffer_d;
   logic [NUM_CH-1:0][15:0] active_q;
   logic [NUM_CH-1:0][15:0] active_d;
   logic [NUM_CH-1:0]       cmp_flag_q;
   logic [NUM_CH-1:0]       cmp_flag_d;
   logic [NUM_CH-1:0]       oe_q;
   logic [NUM_CH-1:0]       oe_d;
   logic [NUM_CH-1:0]       wave;
   logic [NUM_CH-1:0]       match;
   logic [NUM_CH-1:0]       cmp_write;
   logic [NUM_CH-1:0]       cmp_clear;
   logic [NUM_CH-1:0][1:0]  out_mode;
   logic [NUM_CH-1:0]       pin_dir;
   logic [NUM_CH-1:0]       toggle_ok;
   logic [NUM_CH-1:0]       connected;

   // Mode decode
   wire mode_pc_fixed8  = waveform_mode_select == MODE_PC_8;
   wire mode_pc_fixed9  = waveform_mode_select == MODE_PC_9;
   wire mode_pc_fixed10 = waveform_mode_select == MODE_PC_10;
   wire mode_pc_cap     = waveform_mode_select == MODE_PC_CAP;
   wire mode_pc_cmpa    = waveform_mode_select == MODE_PC_CMPA;
   wire mode_pfc_cap    = waveform_mode_select == MODE_PFC_CAP;
   wire mode_pfc_cmpa   = waveform_mode_select == MODE_PFC_CMPA;

   wire fixed_top  = mode_pc_fixed8 || mode_pc_fixed9 || mode_pc_fixed10;
   wire phase_corr = fixed_top || mode_pc_cap || mode_pc_cmpa;
   wire freq_corr  = mode_pfc_cap || mode_pfc_cmpa;
   wire dual_slope = phase_corr || freq_corr;
   wire top_is_cap = mode_pc_cap || mode_pfc_cap;
   wire top_is_a   = mode_pc_cmpa || mode_pfc_cmpa;

   // TOP select; compare A as TOP is its active copy, so a new TOP takes effect at update
   wire [15:0] top_value =
      mode_pc_fixed8  ? TOP_8BIT :
      mode_pc_fixed9  ? TOP_9BIT :
      mode_pc_fixed10 ? TOP_10BIT :
      top_is_cap      ? capture_top_q :
      top_is_a        ? active_q[CH_A] :
                        FULL_MASK;

   // Writes to compare registers are masked to the fixed resolution
   wire [15:0] write_mask =
      mode_pc_fixed8  ? TOP_8BIT :
      mode_pc_fixed9  ? TOP_9BIT :
      mode_pc_fixed10 ? TOP_10BIT :
                        FULL_MASK;
   wire [15:0] masked_data = write_data & write_mask;

   wire step     = timer_tick && dual_slope;
   wire at_top   = counter_q == top_value;
   wire at_bottom = counter_q == BOTTOM;
   wire top_tick = step && at_top;
   wire bot_tick = step && at_bottom;

   // Update point: TOP for phase correct, BOTTOM for frequency correct
   wire load_pc  = top_tick && phase_corr;
   wire load_pfc = bot_tick && freq_corr;
   wire load_buf = load_pc || load_pfc;

   // Effective slope at the extremes
   wire count_up = at_bottom ? 1'b1 : (at_top ? 1'b0 : !down_q);

   assign cnt_bus.tick        = timer_tick;
   assign cnt_bus.dual_active = dual_slope;
   assign cnt_bus.counter     = counter_q;
   assign cnt_bus.count_up    = count_up;

   // Counter and direction
   always_comb begin
      counter_d = counter_q;
      down_d    = down_q;
      if (!dual_slope) begin
         down_d = 1'b0;
      end else if (timer_tick) begin
         if (down_q) begin
            if (at_bottom) begin
               down_d    = 1'b0;
               counter_d = counter_q + COUNT_STEP;
            end else begin
               counter_d = counter_q - COUNT_STEP;
            end
         end else if (at_top) begin
            down_d    = 1'b1;
            counter_d = counter_q - COUNT_STEP;
         end else begin
            // A TOP lowered under the count is missed; the count runs on and wraps
            counter_d = counter_q + COUNT_STEP;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         counter_q <= RESET_VALUE;
         down_q    <= 1'b0;
      end else begin
         counter_q <= counter_d;
         down_q    <= down_d;
      end
   end

   // Capture register used as TOP is not double buffered
   assign capture_top_d = capture_top_write ? write_data : capture_top_q;

   always_ff @(posedge clock) begin
      if (rst) begin
         capture_top_q <= RESET_VALUE;
      end else begin
         capture_top_q <= capture_top_d;
      end
   end

   // Per-channel control grouping
   assign cmp_write = {compare_write_b, compare_write_a};
   assign cmp_clear = {compare_flag_clear_b, compare_flag_clear_a};
   assign out_mode  = {output_mode_select_b, output_mode_select_a};
   assign pin_dir   = {output_pin_direction_b, output_pin_direction_a};

   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
         // Toggle only on channel A with compare A as TOP
         assign toggle_ok[ch] = (ch == CH_A) && top_is_a;

         assign connected[ch] =
            (out_mode[ch] == OUT_NONINV) || (out_mode[ch] == OUT_INV) ||
            ((out_mode[ch] == OUT_TOGGLE) && toggle_ok[ch]);

         // A write lands in the buffer; outside dual-slope modes it applies at once
         assign buffer_d[ch] = cmp_write[ch] ? masked_data : buffer_q[ch];
         assign active_d[ch] =
            !dual_slope ? buffer_d[ch] :
            load_buf    ? buffer_q[ch] :
                          active_q[ch];

         // Set beats clear in the same cycle; compare A as TOP flags at TOP
         assign cmp_flag_d[ch] =
            match[ch] || ((ch == CH_A) && top_tick && top_is_a) ||
            (cmp_flag_q[ch] && !cmp_clear[ch]);

         assign oe_d[ch] = connected[ch] && pin_dir[ch];

         always_ff @(posedge clock) begin
            if (rst) begin
               buffer_q[ch]   <= RESET_VALUE;
               active_q[ch]   <= RESET_VALUE;
               cmp_flag_q[ch] <= 1'b0;
               oe_q[ch]       <= 1'b0;
            end else begin
               buffer_q[ch]   <= buffer_d[ch];
               active_q[ch]   <= active_d[ch];
               cmp_flag_q[ch] <= cmp_flag_d[ch];
               oe_q[ch]       <= oe_d[ch];
            end
         end

         dspwm_channel u_dspwm_channel (
            .clock     (clock),
            .rst       (rst),
            .cnt       (cnt_bus.chan),
            .compare   (active_q[ch]),
            .out_mode  (out_mode[ch]),
            .toggle_ok (toggle_ok[ch]),
            .match     (match[ch]),
            .wave_q    (wave[ch])
         );
      end
   endgenerate

   // Overflow at BOTTOM in both dual-slope modes, same cycle as the PFC update
   assign overflow_d = bot_tick || (overflow_q && !overflow_flag_clear);

   // Capture flag marks TOP when the capture register defines it
   assign capture_flag_d =
      (top_tick && top_is_cap) || (capture_flag_q && !capture_flag_clear);

   always_ff @(posedge clock) begin
      if (rst) begin
         overflow_q     <= 1'b0;
         capture_flag_q <= 1'b0;
      end else begin
         overflow_q     <= overflow_d;
         capture_flag_q <= capture_flag_d;
      end
   end

   // Outputs, all straight from flip-flops
   assign counter_value        = counter_q;
   assign count_down           = down_q;
   assign compare_value_a      = active_q[CH_A];
   assign compare_value_b      = active_q[1];
   assign capture_top_register = capture_top_q;
   assign overflow_flag        = overflow_q;
   assign capture_flag         = capture_flag_q;
   assign compare_flag_a       = cmp_flag_q[CH_A];
   assign compare_flag_b       = cmp_flag_q[1];
   assign compare_output_a     = wave[CH_A];
   assign compare_output_b     = wave[1];
   assign compare_output_a_oe  = oe_q[CH_A];
   assign compare_output_b_oe  = oe_q[1];
endmodule // dspwm_timer

// ### bench/dspwm_chk.sv
// Port assertions for the dual-slope PWM timer
`timescale 1ns/1ps
module dspwm_chk
   import dspwm_pkg::*;
(
   input wire logic        clock,
   input wire logic        rst,
   input wire logic        timer_tick,
   input wire logic [3:0]  waveform_mode_select,
   input wire logic [1:0]  output_mode_select_a,
   input wire logic        output_pin_direction_a,
   input wire logic [15:0] counter_value,
   input wire logic        count_down,
   input wire logic [15:0] compare_value_a,
   input wire logic [15:0] capture_top_register,
   input wire logic        overflow_flag,
   input wire logic        capture_flag,
   input wire logic        compare_flag_a,
   input wire logic        compare_output_a,
   input wire logic        compare_output_a_oe
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   wire [3:0]  wm  = waveform_mode_select;
   wire [15:0] cv  = counter_value;
   wire [1:0]  om  = output_mode_select_a;
   wire        tgl = wm inside {4'h9, 4'hb};
   wire        tk  = timer_tick && (wm inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb});
   wire        hit = tk && cv == compare_value_a;
   property p_hold; !timer_tick |=> $stable(cv); endproperty
   a_hold: assert property (p_hold) else $error("count moved off tick");
   property p_bot; tk && cv == BOTTOM |=> overflow_flag && cv == COUNT_STEP && !count_down;
   endproperty
   a_bot: assert property (p_bot) else $error("bad turn at bottom");
   property p_top8; timer_tick && wm == MODE_PC_8 && cv == TOP_8BIT
      |=> count_down && cv == TOP_8BIT - COUNT_STEP; endproperty
   a_top8: assert property (p_top8) else $error("bad turn at top");
   property p_cap; tk && wm inside {4'h8, 4'ha} && cv == capture_top_register
      |=> capture_flag; endproperty
   a_cap: assert property (p_cap) else $error("capture flag missed");
   property p_cmp; hit |=> compare_flag_a; endproperty
   a_cmp: assert property (p_cmp) else $error("compare flag missed");
   property p_pwm; hit && count_down && cv != BOTTOM && om[1] |=> compare_output_a == !om[0];
   endproperty
   a_pwm: assert property (p_pwm) else $error("down match level wrong");
   property p_tgl; hit && tgl && om == OUT_TOGGLE
      |=> compare_output_a != $past(compare_output_a); endproperty
   a_tgl: assert property (p_tgl) else $error("no toggle");
   // Enable is registered, so it is judged one cycle after its cause
   property p_oe; !output_pin_direction_a |=> !compare_output_a_oe; endproperty
   a_oe: assert property (p_oe) else $error("pin driven as input");
   property p_dis; om == OUT_TOGGLE && !tgl |=> !compare_output_a_oe; endproperty
   a_dis: assert property (p_dis) else $error("toggle not disconnected");
endmodule // dspwm_chk

bind dspwm_timer dspwm_chk u_dspwm_chk (.clock, .rst, .timer_tick, .waveform_mode_select,
   .output_mode_select_a, .output_pin_direction_a, .counter_value, .count_down,
   .compare_value_a, .capture_top_register, .overflow_flag, .capture_flag,
   .compare_flag_a, .compare_output_a, .compare_output_a_oe);

// ### bench/dspwm_load.sv
// Load on one compare output pin: counts cycles the pin is high
`timescale 1ns/1ps
module dspwm_load (
   input  wire logic        clock,
   input  wire logic        drive,
   input  wire logic        oe,
   input  wire logic        meas,
   output      logic [15:0] high_count_q
);
   logic last_q = 1'b0;
   // No pull on the line, so a released pin wanders instead of holding
   wire  pin = oe ? drive : ~last_q;
   always_ff @(posedge clock) begin
      last_q <= pin;
      high_count_q <= !meas ? 16'h0000 : high_count_q + {15'h0000, pin};
   end
endmodule // dspwm_load

// ### bench/dspwm_timer_bench.sv
// Self-checking bench for the dual-slope PWM timer
`timescale 1ns/1ps
module dspwm_timer_bench
   import dspwm_pkg::*;
;
   logic clock = 1'b0, rst = 1'b1, tick = 1'b0, meas = 1'b0, clr = 1'b0;
   logic dira = 1'b0, dirb = 1'b1, cdn, ovf, capf, cfa, cfb, oa, ob, oea, oeb;
   logic [2:0]  wr = 3'h0;
   logic [3:0]  wm = 4'h0;
   logic [1:0]  oma = 2'h0, omb = 2'h0;
   logic [15:0] wd = 16'h0000, t = 16'h0000, tp, cv, cva, cvb, hca, hcb, ctr;
   int          fail_count = 0, comparisons = 0, div = 1, dcnt = 0;
   dspwm_timer u_dspwm_timer (.clock, .rst, .timer_tick(tick), .waveform_mode_select(wm),
      .output_mode_select_a(oma), .output_mode_select_b(omb), .output_pin_direction_a(dira),
      .output_pin_direction_b(dirb), .write_data(wd), .compare_write_a(wr[0]),
      .compare_write_b(wr[1]), .capture_top_write(wr[2]), .overflow_flag_clear(clr),
      .capture_flag_clear(clr), .compare_flag_clear_a(clr), .compare_flag_clear_b(clr),
      .counter_value(cv), .count_down(cdn), .compare_value_a(cva), .compare_value_b(cvb),
      .capture_top_register(ctr), .overflow_flag(ovf), .capture_flag(capf),
      .compare_flag_a(cfa), .compare_flag_b(cfb), .compare_output_a(oa), .compare_output_b(ob),
      .compare_output_a_oe(oea), .compare_output_b_oe(oeb));
   dspwm_load u_load_a (.clock, .drive(oa), .oe(oea), .meas, .high_count_q(hca));
   dspwm_load u_load_b (.clock, .drive(ob), .oe(oeb), .meas, .high_count_q(hcb));
   initial forever #2.5 clock = ~clock;
   // Prescaler stand-in: one tick every div cycles
   always @(negedge clock) begin
      tick <= (dcnt == 0);
      dcnt <= (dcnt + 1) % div;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   function automatic logic [15:0] top_of(input logic [3:0] m);
      case (m)
         MODE_PC_8: return TOP_8BIT;
         MODE_PC_9: return TOP_9BIT;
         MODE_PC_10: return TOP_10BIT;
         default: return t;
      endcase
   endfunction
   // High cycles over two full periods of 2*TOP ticks each
   function automatic logic [31:0] exp_high(input logic [1:0] om, input logic [15:0] c);
      case (om)
         OUT_NONINV: return 4 * c * div;
         OUT_INV: return 4 * (tp - c) * div;
         default: return 2 * tp * div;
      endcase
   endfunction
   task automatic put(input logic [2:0] k, input logic [15:0] d);
      @(negedge clock);
      wd = d;
      wr = k;
      @(negedge clock);
      wr = 3'h0;
   endtask
   task automatic chan(input logic [1:0] om, input logic [15:0] c, input logic con, oe,
                       input logic [15:0] hc);
      if (con) check(hc, exp_high(om, c));
      else check(oe, 1'b0);
   endtask
   task automatic run(input logic [3:0] m, input logic [15:0] ca, cb, input logic [1:0] a, b,
                      input int d);
      int   n;
      logic fx;
      @(negedge clock);
      wm = 4'h0;
      rst = 1'b1;
      div = d;
      @(negedge clock);
      rst = 1'b0;
      tp = top_of(m);
      fx = m inside {MODE_PC_8, MODE_PC_9, MODE_PC_10};
      // Other modes take writes while idle, so TOP is valid before counting
      if (fx) wm = m;
      put(3'h1, fx ? ca | ~tp : ca);
      put(3'h2, fx ? cb | ~tp : cb);
      put(3'h4, t);
      {oma, omb, wm} = {a, b, m};
      dira = (d == 1);
      repeat (4 * tp * d + 8) @(negedge clock);
      check(cva, ca);
      check(cvb, cb);
      for (n = 0; n < 70000 && !(cdn === 1'b1 && cv === tp - 16'h0001); n++) @(negedge clock);
      if (n == 70000) begin
         fail_count++;
         wrap_up();
      end
      meas = 1'b1;
      repeat (4 * tp * d) @(negedge clock);
      chan(a, ca, dira && (a[1] || (a == OUT_TOGGLE && m inside {4'h9, 4'hb})), oea, hca);
      chan(b, cb, b[1], oeb, hcb);
      check(ovf, 1'b1);
      check(cfa, 1'b1);
      check(cfb, 1'b1);
      check(ctr, t);
      check(capf, m inside {MODE_PFC_CAP, MODE_PC_CAP});
      meas = 1'b0;
      wm = 4'h0;
      clr = 1'b1;
      @(negedge clock);
      clr = 1'b0;
      @(negedge clock);
      check(ovf, 1'b0);
      $display("case mode %h done", m);
   endtask
   task automatic wait_dir(input logic want);
      int n;
      for (n = 0; n < 4000 && cdn !== want; n++) @(negedge clock);
      if (n == 4000) begin
         fail_count++;
         wrap_up();
      end
   endtask
   // TOP moved on the way down: phase correct peaks once more at the old TOP
   task automatic retop(input logic [3:0] m, input logic [15:0] t2);
      @(negedge clock);
      wm = 4'h0;
      rst = 1'b1;
      div = 1;
      @(negedge clock);
      rst = 1'b0;
      put(3'h1, t);
      wm = m;
      wait_dir(1'b1);
      put(3'h1, t2);
      wait_dir(1'b0);
      wait_dir(1'b1);
      check(cv, (m == MODE_PC_CMPA ? t : t2) - 16'h0001);
      wait_dir(1'b0);
      wait_dir(1'b1);
      check(cv, t2 - 16'h0001);
      check(cva, t2);
      wm = 4'h0;
      $display("case retop %h done", m);
   endtask
   initial begin
      void'($urandom(32'habe54254));
      repeat (12) @(negedge clock);
      run(MODE_PC_8, 16'($urandom_range(255)), 16'h0000, OUT_NONINV, OUT_INV, 1);
      run(MODE_PC_9, TOP_9BIT, 16'($urandom_range(511)), OUT_NONINV, OUT_NONINV, 1);
      run(MODE_PC_10, 16'($urandom_range(1023)), 16'h0005, OUT_INV, OUT_TOGGLE, 1);
      t = 16'($urandom_range(40, 3));
      run(MODE_PC_CAP, 16'($urandom_range(t)), t, OUT_NONINV, OUT_INV, 8);
      run(MODE_PC_CMPA, t, 16'($urandom_range(t)), OUT_TOGGLE, OUT_NONINV, 1);
      run(MODE_PFC_CAP, 16'($urandom_range(t)), 16'($urandom_range(t)), OUT_INV, OUT_NONINV, 1);
      run(MODE_PFC_CMPA, t, 16'($urandom_range(t)), OUT_TOGGLE, OUT_OFF, 1);
      retop(MODE_PC_CMPA, t + 16'($urandom_range(20, 1)));
      retop(MODE_PFC_CMPA, t + 16'($urandom_range(20, 1)));
      wrap_up();
   end
endmodule // dspwm_timer_bench
